// [include/gpc_pkg.sv]
// package for the geared pulse counters: map, reset values, carriers
`default_nettype none
package gpc_pkg;
  // widths
  localparam int C1_W = 32;
  localparam int C2_W = 16;
  localparam int GEAR_W = 16;
  localparam int ADDR_W = 8;
  localparam int PROD_W = C1_W + GEAR_W;
  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_C1_RAW = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_C1_GEARED = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_C1_TARGET = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_C1_CEIL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_GEAR_NUM = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_GEAR_DEN = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_C2_VALUE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_C2_TARGET = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_C2_CEIL = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_OVF_CFG = 8'h24;
  // values after reset
  localparam logic [C1_W-1:0] RST_C1_TARGET = 32'h0000_03E8;
  localparam logic [C1_W-1:0] RST_C1_CEIL = 32'hFFFF_FFFF;
  localparam logic [GEAR_W-1:0] RST_GEAR = 16'h0001;
  localparam logic [C2_W-1:0] RST_C2_TARGET = 16'h03E8;
  localparam logic [C2_W-1:0] RST_C2_CEIL = 16'hFFFF;
  localparam logic [15:0] RST_OVF_CFG = 16'h000B;
  // overflow configuration digit coding
  localparam logic [15:0] OVF_RADIX = 16'h000A;
  localparam logic [15:0] OVF_CONTINUE = 16'h0001;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // software settings
  typedef struct packed {
    logic [C1_W-1:0] c1_target;
    logic [C1_W-1:0] c1_ceil;
    logic [GEAR_W-1:0] gear_num;
    logic [GEAR_W-1:0] gear_den;
    logic [C2_W-1:0] c2_target;
    logic [C2_W-1:0] c2_ceil;
    logic [15:0] ovf_cfg;
  } gpc_cfg_t;

  // bus slave state
  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
  } gpc_wr_t;
endpackage : gpc_pkg
`default_nettype wire

// [verilog/gpc_counters.sv]
// geared 32-bit pulse counter and plain 16-bit counter behind an axi4-lite slave
// Contract
// - counter one: 32 bits, geared before compare
// - counter two: 16 bits, no gear
// - counter one pulses from count input
// - reach output at set value, keep counting
// - clear input holds counter one at zero
// - gear numerator, denominator 1..65535, default 1
// - counter one set value 1..max, default 1000
// - counter one maximum, default all ones
// - value above maximum means overflow action
// - units digit: counter one stop/continue
// - tens digit: counter two stop/continue
// - raw and geared values readable only
// - values kept over power loss, read only
`default_nettype none
module gpc_counters (
  input wire logic clk,
  input wire logic nrst,
  input wire logic count1_pulse_in,
  input wire logic first_counter_clear_input,
  input wire logic count2_pulse_in,
  input wire logic nv_load,
  input wire logic [31:0] nv_count1_raw,
  input wire logic [15:0] nv_count2,
  output logic count1_reach,
  output logic count2_reach,
  output logic [31:0] count1_raw_value,
  output logic [15:0] count2_value,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge_fn(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction : merge_fn

  // raw count scaled by num/den; saturates rather than wrapping past 32 bits
  function automatic logic [31:0] gear_fn(input logic [31:0] raw, input logic [15:0] num,
                                          input logic [15:0] den);
    logic [gpc_pkg::PROD_W-1:0] prod;
    logic [gpc_pkg::PROD_W-1:0] quot;
    prod = raw * num;
    quot = prod / {32'h0000_0000, den};
    return (quot[gpc_pkg::PROD_W-1:32] != 16'h0000) ? 32'hFFFF_FFFF : quot[31:0];
  endfunction : gear_fn

  // one decimal digit of the overflow configuration is 1
  function automatic logic ovf_cont_fn(input logic [15:0] cfg, input logic tens);
    logic [15:0] v;
    v = tens ? (cfg / gpc_pkg::OVF_RADIX) : cfg;
    return (v % gpc_pkg::OVF_RADIX) == gpc_pkg::OVF_CONTINUE;
  endfunction : ovf_cont_fn

  gpc_pkg::gpc_cfg_t cfg;
  gpc_pkg::gpc_cfg_t next_cfg;
  gpc_pkg::gpc_wr_t wr;
  gpc_pkg::gpc_wr_t next_wr;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, geared, next_geared, next_raw, mw;
  logic [15:0] next_count2;
  logic prev1, prev2, next_reach1, next_reach2, do_write;
  logic rise1, rise2, over1, over2, cont1, cont2;

  // bus slave and settings: a write lands only once address and data are both held
  always_comb
  begin
    next_cfg = cfg;
    next_wr = wr;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    mw = 32'h0000_0000;
    if (awvalid && awready)
    begin
      next_wr.aw_full = 1'b1;
      next_wr.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_wr.w_full = 1'b1;
      next_wr.w_data = wdata;
      next_wr.w_strb = wstrb;
    end
    if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
    end
    do_write = wr.aw_full && wr.w_full && !bvalid;
    if (do_write)
    begin
      next_wr.aw_full = 1'b0;
      next_wr.w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = gpc_pkg::RESP_OKAY;
      case (wr.aw_addr)
        // zero is outside every set-value, maximum and gear range, so a write there that would give zero is dropped
        // counter one set value
        gpc_pkg::OFF_C1_TARGET:
        begin
          mw = merge_fn(cfg.c1_target, wr.w_data, wr.w_strb);
          if (mw != 32'h0000_0000) next_cfg.c1_target = mw;
        end
        gpc_pkg::OFF_C1_CEIL:
        begin
          mw = merge_fn(cfg.c1_ceil, wr.w_data, wr.w_strb);
          if (mw != 32'h0000_0000) next_cfg.c1_ceil = mw;
        end
        gpc_pkg::OFF_GEAR_NUM:
        begin
          mw = merge_fn({16'h0000, cfg.gear_num}, wr.w_data, wr.w_strb);
          if (mw[15:0] != 16'h0000) next_cfg.gear_num = mw[15:0];
        end
        gpc_pkg::OFF_GEAR_DEN:
        begin
          mw = merge_fn({16'h0000, cfg.gear_den}, wr.w_data, wr.w_strb);
          if (mw[15:0] != 16'h0000) next_cfg.gear_den = mw[15:0];
        end
        gpc_pkg::OFF_C2_TARGET:
        begin
          mw = merge_fn({16'h0000, cfg.c2_target}, wr.w_data, wr.w_strb);
          if (mw[15:0] != 16'h0000) next_cfg.c2_target = mw[15:0];
        end
        gpc_pkg::OFF_C2_CEIL:
        begin
          mw = merge_fn({16'h0000, cfg.c2_ceil}, wr.w_data, wr.w_strb);
          if (mw[15:0] != 16'h0000) next_cfg.c2_ceil = mw[15:0];
        end
        gpc_pkg::OFF_OVF_CFG:
        begin
          mw = merge_fn({16'h0000, cfg.ovf_cfg}, wr.w_data, wr.w_strb);
          next_cfg.ovf_cfg = mw[15:0];
        end
        // counter values take no write, answered okay
        gpc_pkg::OFF_C1_RAW, gpc_pkg::OFF_C1_GEARED, gpc_pkg::OFF_C2_VALUE: next_bresp = gpc_pkg::RESP_OKAY;
        default:
        begin
          next_bresp = gpc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = gpc_pkg::RESP_OKAY;
      case (araddr)
        gpc_pkg::OFF_C1_RAW: next_rdata = count1_raw_value;
        gpc_pkg::OFF_C1_GEARED: next_rdata = geared;
        gpc_pkg::OFF_C1_TARGET: next_rdata = cfg.c1_target;
        gpc_pkg::OFF_C1_CEIL: next_rdata = cfg.c1_ceil;
        gpc_pkg::OFF_GEAR_NUM: next_rdata = {16'h0000, cfg.gear_num};
        gpc_pkg::OFF_GEAR_DEN: next_rdata = {16'h0000, cfg.gear_den};
        gpc_pkg::OFF_C2_VALUE: next_rdata = {16'h0000, count2_value};
        gpc_pkg::OFF_C2_TARGET: next_rdata = {16'h0000, cfg.c2_target};
        gpc_pkg::OFF_C2_CEIL: next_rdata = {16'h0000, cfg.c2_ceil};
        gpc_pkg::OFF_OVF_CFG: next_rdata = {16'h0000, cfg.ovf_cfg};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = gpc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // one of each channel in flight; ready drops while its slot is occupied
    next_awready = !next_wr.aw_full;
    next_wready = !next_wr.w_full;
    next_arready = !next_rvalid;
  end

  // bus and settings registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfg <= '{gpc_pkg::RST_C1_TARGET, gpc_pkg::RST_C1_CEIL, gpc_pkg::RST_GEAR, gpc_pkg::RST_GEAR,
               gpc_pkg::RST_C2_TARGET, gpc_pkg::RST_C2_CEIL, gpc_pkg::RST_OVF_CFG};
      wr <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= gpc_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= gpc_pkg::RESP_OKAY;
    end
    else
    begin
      cfg <= next_cfg;
      wr <= next_wr;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // counting: one count per rising edge of a pulse input
  always_comb
  begin
    rise1 = count1_pulse_in && !prev1;
    rise2 = count2_pulse_in && !prev2;
    // overflow is strictly above the maximum
    over1 = geared > cfg.c1_ceil;
    over2 = count2_value > cfg.c2_ceil;
    cont1 = ovf_cont_fn(cfg.ovf_cfg, 1'b0);
    cont2 = ovf_cont_fn(cfg.ovf_cfg, 1'b1);
    next_raw = count1_raw_value;
    next_count2 = count2_value;
    // clear input wins over every other source
    if (first_counter_clear_input)
    begin
      next_raw = 32'h0000_0000;
    end
    // restore from the backing store after power-up
    else if (nv_load)
    begin
      next_raw = nv_count1_raw;
    end
    // stop holds, continue restarts from zero
    else if (over1)
    begin
      next_raw = cont1 ? {31'h0, rise1} : count1_raw_value;
    end
    else if (rise1)
    begin
      next_raw = count1_raw_value + 32'h0000_0001;
    end
    if (nv_load)
    begin
      next_count2 = nv_count2;
    end
    else if (over2 || (rise2 && count2_value >= cfg.c2_ceil))
    begin
      next_count2 = cont2 ? 16'h0000 : count2_value;
    end
    else if (rise2)
    begin
      next_count2 = count2_value + 16'h0001;
    end
    // geared value follows raw one cycle later
    next_geared = gear_fn(count1_raw_value, cfg.gear_num, cfg.gear_den);
    // reach compares the geared value; counting goes on past it
    next_reach1 = geared >= cfg.c1_target;
    next_reach2 = count2_value >= cfg.c2_target;
  end

  // counter registers; values reset to zero, backing store reloads them
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      count1_raw_value <= 32'h0000_0000;
      geared <= 32'h0000_0000;
      count2_value <= 16'h0000;
      prev1 <= 1'b0;
      prev2 <= 1'b0;
      count1_reach <= 1'b0;
      count2_reach <= 1'b0;
    end
    else
    begin
      count1_raw_value <= next_raw;
      geared <= next_geared;
      count2_value <= next_count2;
      prev1 <= count1_pulse_in;
      prev2 <= count2_pulse_in;
      count1_reach <= next_reach1;
      count2_reach <= next_reach2;
    end
  end

  // checks
  AST_REACH1: assert property (@(posedge clk) disable iff (!nrst)
    (geared >= cfg.c1_target) |=> count1_reach)
    else $error("reach output missing at set value");
  AST_CLEAR1: assert property (@(posedge clk) disable iff (!nrst)
    first_counter_clear_input |=> (count1_raw_value == 32'h0000_0000))
    else $error("clear input did not zero counter one");
  AST_COUNT1: assert property (@(posedge clk) disable iff (!nrst)
    (rise1 && !first_counter_clear_input && !nv_load && !over1)
    |=> (count1_raw_value == $past(count1_raw_value) + 32'h0000_0001))
    else $error("counter one missed a pulse");
  AST_GEAR: assert property (@(posedge clk) disable iff (!nrst)
    nrst |=> (geared == gear_fn($past(count1_raw_value), $past(cfg.gear_num), $past(cfg.gear_den))))
    else $error("geared value wrong");
  AST_STOP1: assert property (@(posedge clk) disable iff (!nrst)
    (over1 && !cont1 && !first_counter_clear_input && !nv_load) |=> $stable(count1_raw_value))
    else $error("counter one moved in stop mode");
  AST_WRAP1: assert property (@(posedge clk) disable iff (!nrst)
    (over1 && cont1 && !rise1 && !first_counter_clear_input && !nv_load)
    |=> (count1_raw_value == 32'h0000_0000))
    else $error("counter one did not restart after overflow");
  AST_COUNT2: assert property (@(posedge clk) disable iff (!nrst)
    (rise2 && !nv_load && count2_value < cfg.c2_ceil)
    |=> (count2_value == $past(count2_value) + 16'h0001))
    else $error("counter two missed a pulse");
  AST_OVF2: assert property (@(posedge clk) disable iff (!nrst)
    (rise2 && !nv_load && count2_value >= cfg.c2_ceil)
    |=> (count2_value == (cont2 ? 16'h0000 : $past(count2_value))))
    else $error("counter two overflow action wrong");
  AST_REACH2: assert property (@(posedge clk) disable iff (!nrst)
    (count2_value >= cfg.c2_target) |=> count2_reach)
    else $error("counter two reach missing");
  AST_GEARNZ: assert property (@(posedge clk) disable iff (!nrst)
    (cfg.gear_num != 16'h0000) && (cfg.gear_den != 16'h0000))
    else $error("gear term reached zero");
  AST_BHOLD: assert property (@(posedge clk) disable iff (!nrst)
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped early");

endmodule : gpc_counters
`default_nettype wire

// [tb/gpc_pulse_src.sv]
// behavioural pulse source standing in for the count input terminals
`default_nettype none
module gpc_pulse_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic [2:0] hi_w,
  input wire logic [2:0] lo_w,
  output logic pulse,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // every pulse ends in a low gap of lo_w cycles, so a nonzero lo_w gives each one a fresh rising edge
  initial
  begin
    pulse = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (go)
      begin
        busy <= 1'b1;
        repeat (n_pulses)
        begin
          pulse <= 1'b1;
          repeat (hi_w) @(posedge clk);
          pulse <= 1'b0;
          repeat (lo_w) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : gpc_pulse_src
`default_nettype wire

// [tb/gpc_counters_tb_top.sv]
// self-checking bench for the geared pulse counters
`default_nettype none
module gpc_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic clr = 1'b0;
  logic nv_load = 1'b0;
  logic [31:0] nv1 = 32'h0;
  logic [15:0] nv2 = 16'h0;
  logic go1 = 1'b0;
  logic go2 = 1'b0;
  logic [7:0] np = 8'h01;
  logic [2:0] hw = 3'h2;
  logic [2:0] lw = 3'h2;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic p1, p2, b1, b2, reach1, reach2, awready, wready, bvalid, arready, rvalid;
  logic [31:0] raw1, rdata, rdat, r, g;
  logic [15:0] c2v, num, den;
  logic [1:0] bresp, rresp, brsp, rrsp;
  logic [31:0] seed = 32'h91BA;
  logic [31:0] dv [10];
  int mismatches = 0;
  int n_compared = 0;
  int i, n;

  gpc_counters gpc_counters_i (.clk(clk), .nrst(nrst), .count1_pulse_in(p1), .first_counter_clear_input(clr),
    .count2_pulse_in(p2), .nv_load(nv_load), .nv_count1_raw(nv1), .nv_count2(nv2), .count1_reach(reach1),
    .count2_reach(reach2), .count1_raw_value(raw1), .count2_value(c2v), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  gpc_pulse_src gpc_pulse_src_i (.clk(clk), .go(go1), .n_pulses(np), .hi_w(hw), .lo_w(lw), .pulse(p1), .busy(b1));
  gpc_pulse_src gpc_pulse_src_i2 (.clk(clk), .go(go2), .n_pulses(np), .hi_w(hw), .lo_w(lw), .pulse(p2), .busy(b2));

  always #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = {1'b0, seed[31:1]} ^ (seed[0] ? 32'h8020_0003 : 32'h0);
    return seed;
  endfunction : rnd

  // counter one after n pulses; stop mode ignores pulses once geared passes the ceiling
  function automatic logic [31:0] exp_c1(input int k, input logic [63:0] nm, input logic [63:0] dn,
                                         input logic [63:0] ceil, input bit cont);
    logic [63:0] v;
    v = 64'h0;
    for (int j = 0; j < k; j++)
    begin
      if (cont || v * nm / dn <= ceil)
        v = v + 64'h1;
      if (cont && v * nm / dn > ceil)
        v = 64'h0;
    end
    return v[31:0];
  endfunction : exp_c1

  // geared value: raw times numerator over denominator, pinned at all ones when too large
  function automatic logic [31:0] exp_gear(input logic [63:0] raw, input logic [63:0] nm, input logic [63:0] dn);
    logic [63:0] q;
    q = raw * nm / dn;
    return (q > 64'hFFFF_FFFF) ? 32'hFFFF_FFFF : q[31:0];
  endfunction : exp_gear

  function automatic logic [15:0] exp_c2(input int k, input logic [15:0] ceil, input bit cont);
    logic [15:0] v;
    v = 16'h0;
    for (int j = 0; j < k; j++)
      v = (v >= ceil) ? (cont ? 16'h0 : v) : v + 16'h1;
    return v;
  endfunction : exp_c2

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic hang(input string nm);
    mismatches++;
    $display("CHECK FAILED %s expected answer seen none", nm);
    stop_test();
  endtask : hang

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge clk);
      if (bvalid === 1'b1 && aw_ok && w_ok)
        break;
      if (awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (t == 100)
      hang("write");
    brsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge clk);
      if (rvalid === 1'b1)
        break;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    if (t == 100)
      hang("read");
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
  endtask : rd

  // random widths test both prompt and slow terminals
  task automatic pulses(input bit two, input logic [7:0] cnt);
    int t;
    r = rnd();
    @(posedge clk);
    np <= cnt;
    hw <= 3'h2 + {2'h0, r[0]};
    lw <= 3'h2 + {2'h0, r[1]};
    go1 <= !two;
    go2 <= two;
    @(posedge clk);
    go1 <= 1'b0;
    go2 <= 1'b0;
    for (t = 0; t < 999; t++)
    begin
      @(posedge clk);
      if (!b1 && !b2)
        break;
    end
    if (t == 999)
      hang("pulses");
    repeat (3) @(posedge clk);
  endtask : pulses

  task automatic restore(input logic [31:0] a, input logic [15:0] b, input logic c);
    @(posedge clk);
    nv1 <= a;
    nv2 <= b;
    nv_load <= 1'b1;
    clr <= c;
    @(posedge clk);
    nv_load <= 1'b0;
    clr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : restore

  initial
  begin
    dv = '{32'h0, 32'h0, gpc_pkg::RST_C1_TARGET, gpc_pkg::RST_C1_CEIL, 32'(gpc_pkg::RST_GEAR),
      32'(gpc_pkg::RST_GEAR), 32'h0, 32'(gpc_pkg::RST_C2_TARGET), 32'(gpc_pkg::RST_C2_CEIL),
      32'(gpc_pkg::RST_OVF_CFG)};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      rd(8'(i * 4));
      chk("reset value", dv[i], rdat);
    end
    rd(8'h28);
    chk("unmapped rresp", 32'(gpc_pkg::RESP_SLVERR), 32'(rrsp));
    r = rnd();
    wr(8'h28, r);
    chk("unmapped bresp", 32'(gpc_pkg::RESP_SLVERR), 32'(brsp));
    wr(gpc_pkg::OFF_C1_RAW, r);
    rd(gpc_pkg::OFF_C1_RAW);
    chk("raw after write", 32'h0, rdat);
    wr(gpc_pkg::OFF_GEAR_NUM, 32'h0);
    rd(gpc_pkg::OFF_GEAR_NUM);
    chk("num after zero write", 32'h1, rdat);
    restore(r, r[15:0], 1'b0);
    chk("restored raw", r, raw1);
    chk("restored count2", 32'(r[15:0]), 32'(c2v));
    restore(~r, 16'h0, 1'b1);
    chk("cleared raw", 32'h0, raw1);
    wr(gpc_pkg::OFF_GEAR_NUM, 32'h3);
    wr(gpc_pkg::OFF_C1_TARGET, 32'h3);
    chk("reach idle", 32'h0, 32'(reach1));
    pulses(1'b0, 8'h1);
    chk("reach after one", 32'h1, 32'(reach1));
    pulses(1'b0, 8'h1);
    rd(gpc_pkg::OFF_C1_GEARED);
    chk("geared after two", 32'h6, rdat);
    chk("reach held", 32'h1, 32'(reach1));
    for (i = 0; i < 4; i++)
    begin
      r = rnd();
      num = (i == 0) ? 16'hFFFF : (r[15:0] | 16'h1);
      den = (i == 0) ? 16'h1 : (r[31:16] | 16'h1);
      n = 1 + int'(r[7:4]);
      wr(gpc_pkg::OFF_GEAR_NUM, 32'(num));
      wr(gpc_pkg::OFF_GEAR_DEN, 32'(den));
      restore(32'h0, 16'h0, 1'b1);
      pulses(1'b0, 8'(n));
      g = exp_gear(64'(exp_c1(n, num, den, 64'hFFFF_FFFF, 1'b1)), num, den);
      rd(gpc_pkg::OFF_C1_GEARED);
      chk("geared value", g, rdat);
      chk("reach vs set", 32'(g >= 32'h3), 32'(reach1));
    end
    wr(gpc_pkg::OFF_GEAR_NUM, 32'h1);
    wr(gpc_pkg::OFF_GEAR_DEN, 32'h1);
    wr(gpc_pkg::OFF_C1_CEIL, 32'h5);
    for (i = 0; i < 2; i++)
    begin
      wr(gpc_pkg::OFF_OVF_CFG, 32'(i));
      restore(32'h0, 16'h0, 1'b1);
      pulses(1'b0, 8'h8);
      rd(gpc_pkg::OFF_C1_RAW);
      chk("count1 overflow", exp_c1(8, 1, 1, 5, i[0]), rdat);
    end
    wr(gpc_pkg::OFF_C2_TARGET, 32'h5);
    wr(gpc_pkg::OFF_C2_CEIL, 32'h7);
    for (i = 0; i < 2; i++)
    begin
      wr(gpc_pkg::OFF_OVF_CFG, (i == 1) ? 32'hA : 32'h0);
      restore(32'h0, 16'h0, 1'b1);
      pulses(1'b1, 8'h9);
      chk("count2 value", 32'(exp_c2(9, 16'h7, i[0])), 32'(c2v));
      chk("count2 reach", 32'(exp_c2(9, 16'h7, i[0]) >= 16'h5), 32'(reach2));
    end
    stop_test();
  end
endmodule : gpc_counters_tb_top
`default_nettype wire
